/* File: b2s_pkg.sv */
// constants and state types for the two-word burst split-port sram core
// Notes on behaviour
// - A write starts when the write select is low at a true input clock rise, taking word A+0 there and word A+1 at the next complement rise.
// - A read taken at a true input clock rise in cycle t drives word A+0 at the output complement rise of t+1 and word A+1 at the output true rise of t+2.
// - Write data is sampled on both the true and the complement input clock rises and the controller changes each word together with its edge.
// - With both output clocks held high, read data is aligned to the input clock pair rises instead.
// - Read and write selects are registered only at the true input clock rise and must be stable around it.
// - The data outputs stay in high impedance throughout power-up.
// - While the clocks are stopped all state is kept whatever the selects do, and stopping all four clocks at one level is advised.
// - A low nibble enable 0 writes bits 0 to 3, a low nibble enable 1 writes bits 4 to 7, and both high write nothing for that word.
// - Nibble enables count only inside a started write and are sampled separately at each of the two data captures.
// - With both selects high the device is deselected, does nothing and ignores the address.
// - The address gets one internal low bit, always walking +0 then +1, and the burst ends after two words.
// - A read burst and a write burst may run at the same time, each sequenced from the true input clock.
// - Write addresses are registered at the complement input rise and read addresses at the true input rise.
package b2s_pkg;

  localparam int ADDR_W_DEF = 20; // external address bits of the 8-bit organisation
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int NIB_N = DATA_W / NIB_W;
  localparam int SYNC_STAGES = 2;
  localparam logic [0:0] LSB_FIRST = 1'h0; // internal address bit of word one
  localparam logic [0:0] LSB_SECOND = 1'h1; // internal address bit of word two

  // read sequencer: which burst word is on the output pins
  typedef enum logic [1:0]
  {
    RD_IDLE = 2'b00,
    RD_WORD0 = 2'b01,
    RD_WORD1 = 2'b10
  } b2s_rd_e;

  // write sequencer
  typedef enum logic [1:0]
  {
    WR_IDLE = 2'b00,
    WR_ADDR = 2'b01,
    WR_SECOND = 2'b10
  } b2s_wr_e;

endpackage : b2s_pkg

/* File: b2s_sync.sv */
// two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
module b2s_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second; nothing else may look at it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_r <= '0;
      dout <= '0;
    end
    else
    begin
      meta_r <= din;
      dout <= meta_r;
    end
  end

endmodule : b2s_sync

/* File: b2s_sram.sv */
// sram core: pin-clock edge decode, read and write burst sequencing, storage
`timescale 1ns/100ps
module b2s_sram #(
  parameter int ADDR_W = b2s_pkg::ADDR_W_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic k,
  input wire logic k_n,
  input wire logic c,
  input wire logic c_n,
  input wire logic rd_sel_n,
  input wire logic wr_sel_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [b2s_pkg::DATA_W-1:0] d,
  input wire logic nibble_en0_n,
  input wire logic nibble_en1_n,
  output logic [b2s_pkg::DATA_W-1:0] q,
  output logic q_oe
);

  localparam int DW = b2s_pkg::DATA_W;
  localparam int NN = b2s_pkg::NIB_N;
  // eight single pins (clocks, selects, enables) plus address and data
  localparam int SW = 8 + ADDR_W + DW;

  // the memory array grows as two to the address width plus one, so keep it bounded
  if (ADDR_W < 1 || ADDR_W > 24)
  begin : g_addr_w_bad
    $error("b2s_sram: ADDR_W out of range");
  end

  typedef struct packed {
    logic k_p;
    logic kn_p;
    logic c_p;
    logic cn_p;
    logic rd1_v;
    logic [ADDR_W-1:0] rd1_a;
    logic rd2_v;
    logic [ADDR_W-1:0] rd2_a;
    logic [ADDR_W-1:0] out_a;
    b2s_pkg::b2s_rd_e rd_st;
    logic [DW-1:0] q;
    logic q_oe;
    b2s_pkg::b2s_wr_e wr_st;
    logic [DW-1:0] wr_d0;
    logic [NN-1:0] wr_m0;
    logic [DW-1:0] wr_d1;
    logic [NN-1:0] wr_m1;
    logic [ADDR_W-1:0] wr_a;
    logic go;
    logic [ADDR_W:0] go_a;
    logic [DW-1:0] go_d;
    logic [NN-1:0] go_m;
  } b2s_state_s;

  b2s_state_s s_r;
  b2s_state_s s_nxt;
  logic [DW-1:0] mem [0:(2**(ADDR_W+1))-1];

  // full internal address: external address plus the burst bit
  function automatic logic [ADDR_W:0] addr_cat(input logic [ADDR_W-1:0] a, input logic lsb);
    addr_cat = {a, lsb};
  endfunction : addr_cat

  // nibble merge: a set mask bit takes the new nibble
  function automatic logic [DW-1:0] nib_merge(input logic [DW-1:0] old_v,
                                              input logic [DW-1:0] new_v,
                                              input logic [NN-1:0] m);
    logic [DW-1:0] r;
    r = old_v;
    for (int i = 0; i < NN; i++)
    begin
      if (m[i])
        r[i*b2s_pkg::NIB_W +: b2s_pkg::NIB_W] = new_v[i*b2s_pkg::NIB_W +: b2s_pkg::NIB_W];
    end
    nib_merge = r;
  endfunction : nib_merge

  // every pin comes from another clock domain, so it passes two flops first
  logic [SW-1:0] pins_s;
  logic k_s, kn_s, c_s, cn_s, rdn_s, wrn_s, en0_s, en1_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DW-1:0] d_s;

  b2s_sync #(
    .WIDTH(SW)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din({k, k_n, c, c_n, rd_sel_n, wr_sel_n, nibble_en0_n, nibble_en1_n, addr, d}),
    .dout(pins_s)
  );

  assign {k_s, kn_s, c_s, cn_s, rdn_s, wrn_s, en0_s, en1_s, addr_s, d_s} = pins_s;

  // edge events; data and clocks share one sync delay so setup is kept
  logic ev_k, ev_kn, ev_o0, ev_o1, kmode;
  assign ev_k = k_s & ~s_r.k_p;
  assign ev_kn = kn_s & ~s_r.kn_p;
  assign kmode = c_s & cn_s; // output clocks parked high selects input-clock timing
  assign ev_o0 = kmode ? ev_kn : (cn_s & ~s_r.cn_p);
  assign ev_o1 = kmode ? ev_k : (c_s & ~s_r.c_p);

  // next-state logic; without pin edges only go and the WR_SECOND store step change, so a stopped clock holds state
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.k_p = k_s;
    s_nxt.kn_p = kn_s;
    s_nxt.c_p = c_s;
    s_nxt.cn_p = cn_s;
    s_nxt.go = 1'b0;
    // read pipe: stage one at K(t), stage two from K(t+1)
    if (ev_k)
    begin
      s_nxt.rd2_v = s_r.rd1_v;
      s_nxt.rd2_a = s_r.rd1_a;
      s_nxt.rd1_v = ~rdn_s; // selects are only looked at on a true rise
      if (!rdn_s)
        s_nxt.rd1_a = addr_s; // read address on the true rise
    end
    // first output edge: drive word +0 or release the bus
    if (ev_o0)
    begin
      if (s_r.rd2_v)
      begin
        s_nxt.q = mem[addr_cat(s_r.rd2_a, b2s_pkg::LSB_FIRST)];
        s_nxt.q_oe = 1'b1;
        s_nxt.out_a = s_r.rd2_a;
        s_nxt.rd_st = b2s_pkg::RD_WORD0;
        s_nxt.rd2_v = 1'b0;
      end
      else
      begin
        s_nxt.q_oe = 1'b0;
        s_nxt.rd_st = b2s_pkg::RD_IDLE;
      end
    end
    else if (ev_o1 && s_r.rd_st == b2s_pkg::RD_WORD0)
    begin
      s_nxt.q = mem[addr_cat(s_r.out_a, b2s_pkg::LSB_SECOND)];
      s_nxt.rd_st = b2s_pkg::RD_WORD1; // burst count two reached
    end
    // write sequencer runs beside the read one
    case (s_r.wr_st)
      b2s_pkg::WR_ADDR:
      begin
        if (ev_kn)
        begin
          s_nxt.wr_a = addr_s; // write address on the complement rise
          s_nxt.wr_d1 = d_s; // second word on the complement rise
          s_nxt.wr_m1 = ~{en1_s, en0_s};
          s_nxt.go = |s_r.wr_m0; // both enables high write nothing
          s_nxt.go_a = addr_cat(addr_s, b2s_pkg::LSB_FIRST);
          s_nxt.go_d = s_r.wr_d0;
          s_nxt.go_m = s_r.wr_m0;
          s_nxt.wr_st = b2s_pkg::WR_SECOND;
        end
      end
      b2s_pkg::WR_SECOND:
      begin
        s_nxt.go = |s_r.wr_m1;
        s_nxt.go_a = addr_cat(s_r.wr_a, b2s_pkg::LSB_SECOND);
        s_nxt.go_d = s_r.wr_d1;
        s_nxt.go_m = s_r.wr_m1;
        s_nxt.wr_st = b2s_pkg::WR_IDLE;
      end
      default:
      begin
        s_nxt.wr_st = b2s_pkg::WR_IDLE;
      end
    endcase
    // a write is opened only by a true rise with the select low
    if (ev_k && !wrn_s)
    begin
      s_nxt.wr_st = b2s_pkg::WR_ADDR;
      s_nxt.wr_d0 = d_s; // first word on the true rise
      s_nxt.wr_m0 = ~{en1_s, en0_s}; // enables sampled per word
    end
  end

  // state register; reset leaves the data pins released
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // storage write port, nibble-masked; no reset so it maps to ram
  always_ff @(posedge clk)
  begin
    if (s_r.go)
      mem[s_r.go_a] <= nib_merge(mem[s_r.go_a], s_r.go_d, s_r.go_m);
  end

  assign q = s_r.q;
  assign q_oe = s_r.q_oe;

  // checks next to the sequencers
  sequence wr_open_s;
    ev_k && !wrn_s;
  endsequence

  sequence wr_addr_s;
    s_r.wr_st == b2s_pkg::WR_ADDR && ev_kn && (|s_r.wr_m0) && (|{~en1_s, ~en0_s});
  endsequence

  property hold_when_quiet_p;
    @(posedge clk) disable iff (!rstn)
      (!ev_k && !ev_kn && !ev_o0 && !ev_o1) |=> ($stable(q) && $stable(q_oe));
  endproperty

  write_start_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_open_s |=> s_r.wr_st == b2s_pkg::WR_ADDR)
    else $error("write not opened after select");
  write_pair_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_addr_s |=> s_r.go && !s_r.go_a[0] ##1 s_r.go && s_r.go_a[0])
    else $error("write burst did not store +0 then +1");
  write_mask_a: assert property (@(posedge clk) disable iff (!rstn)
    s_r.go |-> s_r.go_m != '0)
    else $error("store issued with no nibble enabled");
  skip_empty_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_r.wr_st == b2s_pkg::WR_ADDR && ev_kn && s_r.wr_m0 == '0) |=> !s_r.go)
    else $error("word with both enables high was stored");
  read_take_a: assert property (@(posedge clk) disable iff (!rstn)
    (ev_k && !rdn_s) |=> (s_r.rd1_v && s_r.rd1_a == $past(addr_s)))
    else $error("read address not taken on true rise");
  deselect_a: assert property (@(posedge clk) disable iff (!rstn)
    (ev_k && rdn_s) |=> !s_r.rd1_v)
    else $error("read queued while deselected");
  read_first_a: assert property (@(posedge clk) disable iff (!rstn)
    (ev_o0 && s_r.rd2_v) |=> (q_oe && s_r.rd_st == b2s_pkg::RD_WORD0 && s_r.out_a == $past(s_r.rd2_a)))
    else $error("first read word not driven");
  read_second_a: assert property (@(posedge clk) disable iff (!rstn)
    (ev_o1 && !ev_o0 && s_r.rd_st == b2s_pkg::RD_WORD0) |=> (q_oe && s_r.rd_st == b2s_pkg::RD_WORD1))
    else $error("second read word not driven");
  idle_hiz_a: assert property (@(posedge clk) disable iff (!rstn)
    (ev_o0 && !s_r.rd2_v) |=> !q_oe)
    else $error("bus driven with no read pending");
  powerup_hiz_a: assert property (@(posedge clk)
    !rstn |-> !q_oe)
    else $error("data pins driven during reset");
  clock_stop_a: assert property (hold_when_quiet_p)
    else $error("outputs moved with clocks stopped");

endmodule : b2s_sram

/* File: b2s_note_end.sv */
// spare file: holds no logic

/* File: b2s_ctrl.sv */
// controller model: pin clocks, selects, address, write data
`timescale 1ns/100ps
module b2s_ctrl #(
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic [7:0] q,
  input wire logic q_oe,
  output logic k,
  output logic k_n,
  output logic c,
  output logic c_n,
  output logic rd_sel_n,
  output logic wr_sel_n,
  output logic [AW-1:0] addr,
  output logic [7:0] d,
  output logic [1:0] nib_n
);
  // pins idle at time zero: clocks low, selects high
  initial
  begin
    {k, k_n, c, c_n} = 4'h0;
    {rd_sel_n, wr_sel_n, addr, d, nib_n} = '1;
  end

  // one 16-clk pin cycle; cm high runs c/c_n, low parks both high
  task automatic cyc(input logic rd, wr, cm, input logic [AW-1:0] ra, wa,
      input logic [7:0] d0, d1, input logic [1:0] m0, m1, output logic [8:0] sa, sb);
    @(negedge clk);
    {k, k_n, c, c_n} = {3'h5, 1'(!cm)};
    {rd_sel_n, wr_sel_n, addr, d, nib_n} = {!rd, !wr, ra, d0, m0};
    repeat (8) @(negedge clk);
    sa = {q_oe, q};
    {k, k_n, c, c_n} = {2'h1, 1'(!cm), 1'h1};
    // selects go high off the true edge so a stray sample shows
    {rd_sel_n, wr_sel_n, addr, d, nib_n} = {2'h3, wa, d1, m1};
    repeat (7) @(negedge clk);
    sb = {q_oe, q};
  endtask : cyc

  // all four clocks parked low together; low selects must be ignored
  task automatic halt(input int n);
    {k, k_n, c, c_n} = 4'h0;
    {rd_sel_n, wr_sel_n} = 2'h0;
    repeat (n) @(negedge clk);
    {rd_sel_n, wr_sel_n} = 2'h3;
  endtask : halt
endmodule : b2s_ctrl

/* File: testbench.sv */
// self-checking bench for the sram core with random traffic
`timescale 1ns/100ps
module testbench;
  localparam int AW = 4;
  logic clk = 1'b0;
  logic rstn = 1'b1;
  logic k, k_n, c, c_n, rd_sel_n, wr_sel_n, q_oe;
  logic [AW-1:0] addr;
  logic [1:0] nib_n;
  logic [7:0] d, q;
  logic [7:0] mem [2**(AW+1)];
  logic [AW:0] p1, p2; // reads in flight: valid and address
  logic [8:0] hold;
  int n_fail = 0;
  int samples_checked = 0;
  int seed = 88;
  int cyc_n = 0;

  always #2.5 clk = ~clk;

  b2s_ctrl #(.AW(AW)) ctl (.clk(clk), .q(q), .q_oe(q_oe), .k(k), .k_n(k_n), .c(c),
    .c_n(c_n), .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n), .addr(addr), .d(d),
    .nib_n(nib_n));
  b2s_sram #(.ADDR_W(AW)) DUT (.clk(clk), .rstn(rstn), .k(k), .k_n(k_n), .c(c),
    .c_n(c_n), .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n), .addr(addr), .d(d),
    .nibble_en0_n(nib_n[0]), .nibble_en1_n(nib_n[1]), .q(q), .q_oe(q_oe));

  // a high enable keeps the old nibble
  function automatic logic [7:0] merge(logic [7:0] o, logic [7:0] n, logic [1:0] m);
    return {m[1] ? o[7:4] : n[7:4], m[0] ? o[3:0] : n[3:0]};
  endfunction : merge

  // data only matters while the output is enabled
  task automatic chk(input logic [8:0] got, input logic v, input logic [7:0] w);
    samples_checked++;
    if (got[8] !== v || (v && got[7:0] !== w))
    begin
      n_fail++;
      $display("[ERR] %0t got %h want %b %h", $time, got, v, w);
    end
  endtask : chk

  // one pin cycle, then update the reference memory and read pipeline
  task automatic step(input logic rd, wr, cm, input logic [AW-1:0] ra, wa,
      input logic [7:0] d0, d1, input logic [1:0] m0, m1);
    logic [8:0] sa, sb;
    ctl.cyc(rd, wr, cm, ra, wa, d0, d1, m0, m1, sa, sb);
    chk(sa, p2[AW], mem[{p2[AW-1:0], 1'b1}]);
    chk(sb, p1[AW], mem[{p1[AW-1:0], 1'b0}]);
    if (wr)
    begin
      mem[{wa, 1'b0}] = merge(mem[{wa, 1'b0}], d0, m0);
      mem[{wa, 1'b1}] = merge(mem[{wa, 1'b1}], d1, m1);
    end
    p2 = p1;
    p1 = {rd, ra};
  endtask : step

  // deselected cycles with enables low and a random address
  task automatic idle(input logic cm);
    repeat (2) step(1'b0, 1'b0, cm, 4'($random(seed)), 4'h9, 8'h00, 8'h00, 2'h0, 2'h0);
  endtask : idle

  // random concurrent traffic; writes never hit a read still in flight
  task automatic rnd(input logic cm, input int n);
    logic [9:0] r;
    repeat (n)
    begin
      r = 10'($random(seed));
      if (r[7:4] == r[3:0] || r[7:4] == p1[AW-1:0])
        r[8] = 1'b0;
      step(r[9], r[8], cm, r[3:0], r[7:4], 8'($random(seed)), 8'($random(seed)),
        2'($random(seed)), 2'($random(seed)));
    end
  endtask : rnd

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  // hang guard, well above the roughly 3550 clk the run needs
  always @(posedge clk)
  begin
    cyc_n++;
    if (cyc_n == 12000)
    begin
      n_fail++;
      close_out();
    end
  end

  initial
  begin
    p1 = '0;
    p2 = '0;
    // a real falling edge before the first clock, so reset acts at once
    #1 rstn = 1'b0;
    repeat (10) @(negedge clk);
    chk({q_oe, 8'h00}, 1'b0, 8'h00);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 16; i++)
      step(1'b0, 1'b1, 1'b1, 4'h0, 4'(i), 8'($random(seed)), 8'($random(seed)), 2'h0, 2'h0);
    $display("test fill done");
    // every enable pair, changed between the two words
    for (int m = 0; m < 4; m++)
    begin
      step(1'b0, 1'b1, 1'b1, 4'h0, 4'h3, 8'($random(seed)), 8'h5a, 2'(m), 2'(3 - m));
      step(1'b1, 1'b0, 1'b1, 4'h3, 4'h3, 8'h00, 8'h00, 2'h0, 2'h0);
      idle(1'b1);
    end
    $display("test nibble done");
    rnd(1'b1, 120);
    idle(1'b1);
    hold = {q_oe, q};
    ctl.halt(40);
    chk({q_oe, q}, hold[8], hold[7:0]);
    idle(1'b1);
    $display("test stop done");
    rnd(1'b0, 60);
    idle(1'b0);
    $display("test kmode done");
    close_out();
  end
endmodule : testbench
